// ==== include/srs_pkg.sv ====
// constants, encodings and register map of the speed reference source selector
// assumes one 200 MHz control clock and a plain strobe register port
package srs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFF_MODE        = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CHOICE      = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_AUTOCFG_DIS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_SCAN_PERIOD = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PANEL_REF   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_COARSE_REF  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_FINE_REF    = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_LO_DEST     = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_HI_DEST     = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_STATUS      = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PRESET_BASE = 8'h40;
  localparam int                PRESET_STRIDE   = 4;
  localparam int                NUM_PRESETS     = 8;

  // reference source modes
  typedef enum logic [2:0] {
    ANALOG_PAIR_MODE        = 3'h0,
    ANALOG1_PRESET_MODE     = 3'h1,
    ANALOG2_PRESET_MODE     = 3'h2,
    STORED_VALUES_ONLY_MODE = 3'h3,
    PANEL_MODE              = 3'h4,
    FINE_REF_MODE           = 3'h5
  } srs_mode_t;
  localparam logic [2:0] MODE_MAX = 3'h5;

  // preset choice codes
  localparam logic [3:0] CHOICE_TERMINALS = 4'h0;
  localparam logic [3:0] CHOICE_FIRST     = 4'h1;
  localparam logic [3:0] CHOICE_LAST      = 4'h8;
  localparam logic [3:0] CHOICE_SCAN      = 4'h9;

  // selector terminal destinations
  typedef enum logic [2:0] {
    DEST_NONE         = 3'h0,
    DEST_LOCAL_REMOTE = 3'h1,
    DEST_PSEL_BIT0    = 3'h2,
    DEST_PSEL_BIT1    = 3'h3,
    DEST_JOG_FWD      = 3'h4
  } srs_dest_t;

  // drive sequencer state as seen at the input
  typedef enum logic [1:0] {
    DRV_RUN     = 2'h0,
    DRV_READY   = 2'h1,
    DRV_INHIBIT = 2'h2,
    DRV_TRIP    = 2'h3
  } srs_drv_t;

  // reported reference selector (analog 1/2, preset, panel, fine)
  localparam logic [2:0] SEL_ANALOG1 = 3'h1;
  localparam logic [2:0] SEL_ANALOG2 = 3'h2;
  localparam logic [2:0] SEL_PRESET  = 3'h3;
  localparam logic [2:0] SEL_PANEL   = 3'h4;
  localparam logic [2:0] SEL_FINE    = 3'h5;

  // reset values
  localparam logic [2:0] RST_MODE        = 3'h0;
  localparam logic [3:0] RST_CHOICE      = 4'h0;
  localparam logic       RST_AUTOCFG_DIS = 1'b0;

  // scan timer
  localparam int SCAN_W          = 24;
  localparam int CLK_HZ          = 200_000_000;
  localparam int SCAN_DEFAULT_MS = 10;
  localparam int SCAN_DEFAULT_CYC = SCAN_DEFAULT_MS * (CLK_HZ / 1000);

  // status register field positions
  localparam int ST_PRESET_LSB  = 0;
  localparam int ST_SEL_LSB     = 4;
  localparam int ST_APPLIED_LSB = 8;

endpackage

// ==== logic/srs_selector.sv ====
// speed reference source selector: picks the active reference, routes the two
// selector terminals, runs the preset scan timer and owns the parameter set.
// assumes inputs synchronous to i_core_clk, a one-cycle i_drive_reset pulse
// from the drive, and a master that follows the plain strobe register port.
//
// Overview of operation
// R01: with auto-config on, terminal destinations follow the reference source mode
// R02: auto-config disable set stops routing; software may write the destinations
// R03: with auto-config on, a mode change reaches terminals only at drive reset
// R04: preset choice 9 turns on the reference scan timer
// R05: scan steps index one (the mode's analog, or preset one), then presets two to eight, and repeats
// R06: scan dwell comes from the programmable scan period register
// R07: jog forward taken from the high terminal only in ready, inhibit or trip
// R08: eight stored preset values held in eight consecutive registers, one to eight
// R09: panel mode runs the sequencer from panel keys and uses the panel reference
// R10: panel mode ignores external sequencing bits and disables jog
// R11: fine mode builds the reference from coarse and fine registers, terminals ignored
// R12: preset choice two to eight selects that preset, terminals have no effect
// R13: preset modes, choice 0: terminals form a code, 00 base, then presets 2-4
// R14: analog pair mode, choice 0 or 1: low terminal picks analog 1 or 2; high is jog
`timescale 1ns/1ps

module srs_selector #(
  parameter int REF_W      = 16,
  parameter int FINE_W     = 8,
  parameter int SCAN_RESET = srs_pkg::SCAN_DEFAULT_CYC
) (
  // clock, reset, enable
  input  wire logic                       i_core_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_ce,
  // register port
  input  wire logic [srs_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [srs_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [srs_pkg::DATA_W-1:0] o_rdata,
  // terminals and analog inputs
  input  wire logic                       i_selector_input_lo,
  input  wire logic                       i_selector_input_hi,
  input  wire logic [REF_W-1:0]           i_analog1,
  input  wire logic [REF_W-1:0]           i_analog2,
  // panel keys and external sequencing
  input  wire logic                       i_panel_run_key,
  input  wire logic                       i_panel_stop_key,
  input  wire logic                       i_ext_run,
  input  wire logic                       i_ext_jog,
  // drive sequencer side
  input  wire logic [1:0]                 i_drive_state,
  input  wire logic                       i_drive_reset,
  output logic      [REF_W+FINE_W-1:0]    o_reference,
  output logic      [2:0]                 o_ref_selector,
  output logic      [3:0]                 o_preset_index,
  output logic                            o_run_cmd,
  output logic                            o_jog_fwd,
  output logic      [2:0]                 o_lo_dest,
  output logic      [2:0]                 o_hi_dest
);

  logic [2:0]        mode_reg;
  logic [3:0]        choice_reg;
  logic              autocfg_dis_reg;
  logic [2:0]        applied_mode_reg;
  logic [srs_pkg::SCAN_W-1:0] scan_period_reg;
  logic [srs_pkg::SCAN_W-1:0] scan_cnt_reg;
  logic [3:0]        scan_idx_reg;
  logic [REF_W-1:0]  panel_ref_reg;
  logic [REF_W-1:0]  coarse_ref_reg;
  logic [FINE_W-1:0] fine_ref_reg;
  logic [REF_W-1:0]  preset_reg [srs_pkg::NUM_PRESETS];
  logic              panel_run_reg;
  logic [2:0]        sel_next;
  logic [3:0]        idx_next;
  logic [REF_W+FINE_W-1:0] ref_next;
  logic [1:0]        code;
  logic              wr_en;
  logic              rd_en;

  assign wr_en = i_ce & i_wr;
  assign rd_en = i_ce & i_rd;

  // destination a terminal gets from a given mode under auto-config
  function automatic logic [2:0] auto_dest(input logic [2:0] mode, input logic hi);
    logic [2:0] d;
    d = srs_pkg::DEST_NONE;
    case (mode)
      srs_pkg::ANALOG_PAIR_MODE:
        d = hi ? srs_pkg::DEST_JOG_FWD : srs_pkg::DEST_LOCAL_REMOTE;
      srs_pkg::ANALOG1_PRESET_MODE,
      srs_pkg::ANALOG2_PRESET_MODE,
      srs_pkg::STORED_VALUES_ONLY_MODE:
        d = hi ? srs_pkg::DEST_PSEL_BIT1 : srs_pkg::DEST_PSEL_BIT0;
      default:
        d = srs_pkg::DEST_NONE;
    endcase
    return d;
  endfunction

  // a terminal contributes only when its destination matches
  function automatic logic term_is(input logic [2:0] dest, input logic [2:0] want,
                                   input logic level);
    return (dest == want) && level;
  endfunction

  function automatic logic [REF_W+FINE_W-1:0] widen(input logic [REF_W-1:0] v);
    return {v, {FINE_W{1'b0}}};
  endfunction

  // mode and preset choice; out-of-range writes are dropped
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_reg        <= srs_pkg::RST_MODE;
      choice_reg      <= srs_pkg::RST_CHOICE;
      autocfg_dis_reg <= srs_pkg::RST_AUTOCFG_DIS;
    end
    else if (wr_en)
    begin
      if (i_addr == srs_pkg::OFF_MODE && i_wdata[2:0] <= srs_pkg::MODE_MAX)
        mode_reg <= i_wdata[2:0];
      if (i_addr == srs_pkg::OFF_CHOICE && i_wdata[3:0] <= srs_pkg::CHOICE_SCAN)
        choice_reg <= i_wdata[3:0];
      if (i_addr == srs_pkg::OFF_AUTOCFG_DIS)
        autocfg_dis_reg <= i_wdata[0];
    end
  end

  // the terminal routing only picks up a new mode at a drive reset
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      applied_mode_reg <= srs_pkg::RST_MODE;
    else if (i_ce && i_drive_reset)
      applied_mode_reg <= mode_reg; // R03
  end

  // destination routing: hardware owns it unless auto-config is disabled
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_lo_dest <= srs_pkg::DEST_LOCAL_REMOTE;
      o_hi_dest <= srs_pkg::DEST_JOG_FWD;
    end
    else if (i_ce)
    begin
      if (!autocfg_dis_reg)
      begin
        o_lo_dest <= auto_dest(applied_mode_reg, 1'b0); // R01
        o_hi_dest <= auto_dest(applied_mode_reg, 1'b1); // R01
      end
      else if (i_wr)
      begin
        if (i_addr == srs_pkg::OFF_LO_DEST)
          o_lo_dest <= i_wdata[2:0]; // R02
        if (i_addr == srs_pkg::OFF_HI_DEST)
          o_hi_dest <= i_wdata[2:0]; // R02
      end
    end
  end

  // reference value registers
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      scan_period_reg <= srs_pkg::SCAN_W'(SCAN_RESET);
      panel_ref_reg   <= '0;
      coarse_ref_reg  <= '0;
      fine_ref_reg    <= '0;
    end
    else if (wr_en)
    begin
      if (i_addr == srs_pkg::OFF_SCAN_PERIOD)
        scan_period_reg <= i_wdata[srs_pkg::SCAN_W-1:0]; // R06
      if (i_addr == srs_pkg::OFF_PANEL_REF)
        panel_ref_reg <= i_wdata[REF_W-1:0];
      if (i_addr == srs_pkg::OFF_COARSE_REF)
        coarse_ref_reg <= i_wdata[REF_W-1:0];
      if (i_addr == srs_pkg::OFF_FINE_REF)
        fine_ref_reg <= i_wdata[FINE_W-1:0];
    end
  end

  // eight stored presets at consecutive word addresses
  for (genvar g = 0; g < srs_pkg::NUM_PRESETS; g++)
  begin : g_preset
    localparam logic [srs_pkg::ADDR_W-1:0] PRESET_ADDR =
      srs_pkg::ADDR_W'(srs_pkg::OFF_PRESET_BASE + g * srs_pkg::PRESET_STRIDE);
    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
      if (!i_reset_n)
        preset_reg[g] <= '0;
      else if (wr_en && i_addr == PRESET_ADDR)
        preset_reg[g] <= i_wdata[REF_W-1:0]; // R08
    end
  end

  // scan timer: index 1 is the analog (or first preset), then 2..8
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      scan_cnt_reg <= '0;
      scan_idx_reg <= srs_pkg::CHOICE_FIRST;
    end
    else if (i_ce)
    begin
      if (choice_reg != srs_pkg::CHOICE_SCAN)
      begin
        scan_cnt_reg <= '0;
        scan_idx_reg <= srs_pkg::CHOICE_FIRST;
      end
      else if (scan_cnt_reg + 1'b1 >= scan_period_reg) // R06
      begin
        scan_cnt_reg <= '0;
        if (scan_idx_reg == srs_pkg::CHOICE_LAST)
          scan_idx_reg <= srs_pkg::CHOICE_FIRST; // R05
        else
          scan_idx_reg <= scan_idx_reg + 1'b1; // R05
      end
      else
        scan_cnt_reg <= scan_cnt_reg + 1'b1; // R04
    end
  end

  // source selection
  always_comb
  begin
    code = {term_is(o_hi_dest, srs_pkg::DEST_PSEL_BIT1, i_selector_input_hi),
            term_is(o_lo_dest, srs_pkg::DEST_PSEL_BIT0, i_selector_input_lo)};
    if (choice_reg == srs_pkg::CHOICE_SCAN)
      idx_next = scan_idx_reg; // R04
    else if (choice_reg >= srs_pkg::CHOICE_FIRST + 1'b1)
      idx_next = choice_reg; // R12
    else if (choice_reg == srs_pkg::CHOICE_TERMINALS && mode_reg != srs_pkg::ANALOG_PAIR_MODE)
      idx_next = srs_pkg::CHOICE_FIRST + {2'b00, code}; // R13
    else
      idx_next = srs_pkg::CHOICE_FIRST;
    case (mode_reg)
      srs_pkg::ANALOG_PAIR_MODE:
        sel_next = term_is(o_lo_dest, srs_pkg::DEST_LOCAL_REMOTE, i_selector_input_lo)
                   ? srs_pkg::SEL_ANALOG2 : srs_pkg::SEL_ANALOG1; // R14
      srs_pkg::ANALOG1_PRESET_MODE:     sel_next = srs_pkg::SEL_ANALOG1;
      srs_pkg::ANALOG2_PRESET_MODE:     sel_next = srs_pkg::SEL_ANALOG2;
      srs_pkg::STORED_VALUES_ONLY_MODE: sel_next = srs_pkg::SEL_PRESET;
      srs_pkg::PANEL_MODE:              sel_next = srs_pkg::SEL_PANEL;
      default:                          sel_next = srs_pkg::SEL_FINE;
    endcase
    case (sel_next)
      srs_pkg::SEL_PANEL:
        ref_next = widen(panel_ref_reg); // R09
      srs_pkg::SEL_FINE:
        ref_next = {coarse_ref_reg, fine_ref_reg}; // R11
      default:
        if (idx_next != srs_pkg::CHOICE_FIRST || sel_next == srs_pkg::SEL_PRESET)
          ref_next = widen(preset_reg[idx_next[2:0] - 3'h1]);
        else if (sel_next == srs_pkg::SEL_ANALOG2)
          ref_next = widen(i_analog2);
        else
          ref_next = widen(i_analog1);
    endcase
    if (sel_next == srs_pkg::SEL_PANEL || sel_next == srs_pkg::SEL_FINE)
      idx_next = '0;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reference    <= '0;
      o_ref_selector <= srs_pkg::SEL_ANALOG1;
      o_preset_index <= srs_pkg::CHOICE_FIRST;
    end
    else if (i_ce)
    begin
      o_reference    <= ref_next;
      o_ref_selector <= sel_next;
      o_preset_index <= idx_next;
    end
  end

  // run and jog: panel keys take over in panel mode, stop key wins
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      panel_run_reg <= 1'b0;
    else if (i_ce)
    begin
      if (i_panel_stop_key)
        panel_run_reg <= 1'b0;
      else if (i_panel_run_key && mode_reg == srs_pkg::PANEL_MODE)
        panel_run_reg <= 1'b1; // R09
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_run_cmd <= 1'b0;
      o_jog_fwd <= 1'b0;
    end
    else if (i_ce)
    begin
      if (mode_reg == srs_pkg::PANEL_MODE)
      begin
        o_run_cmd <= panel_run_reg; // R10
        o_jog_fwd <= 1'b0; // R10
      end
      else
      begin
        o_run_cmd <= i_ext_run;
        // jog from the high terminal is honoured only while the output is off
        o_jog_fwd <= (i_drive_state != srs_pkg::DRV_RUN) &&
                     (i_ext_jog ||
                      term_is(o_hi_dest, srs_pkg::DEST_JOG_FWD, i_selector_input_hi)); // R07
      end
    end
  end

  // read data one cycle after the read strobe; unmapped reads give zero
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_rdata <= '0;
    else if (i_ce)
    begin
      o_rdata <= '0;
      if (rd_en)
      begin
        if (i_addr == srs_pkg::OFF_MODE)
          o_rdata <= srs_pkg::DATA_W'(mode_reg);
        else if (i_addr == srs_pkg::OFF_CHOICE)
          o_rdata <= srs_pkg::DATA_W'(choice_reg);
        else if (i_addr == srs_pkg::OFF_AUTOCFG_DIS)
          o_rdata <= srs_pkg::DATA_W'(autocfg_dis_reg);
        else if (i_addr == srs_pkg::OFF_SCAN_PERIOD)
          o_rdata <= srs_pkg::DATA_W'(scan_period_reg);
        else if (i_addr == srs_pkg::OFF_PANEL_REF)
          o_rdata <= srs_pkg::DATA_W'(panel_ref_reg);
        else if (i_addr == srs_pkg::OFF_COARSE_REF)
          o_rdata <= srs_pkg::DATA_W'(coarse_ref_reg);
        else if (i_addr == srs_pkg::OFF_FINE_REF)
          o_rdata <= srs_pkg::DATA_W'(fine_ref_reg);
        else if (i_addr == srs_pkg::OFF_LO_DEST)
          o_rdata <= srs_pkg::DATA_W'(o_lo_dest);
        else if (i_addr == srs_pkg::OFF_HI_DEST)
          o_rdata <= srs_pkg::DATA_W'(o_hi_dest);
        else if (i_addr == srs_pkg::OFF_STATUS)
        begin
          o_rdata[srs_pkg::ST_PRESET_LSB +: 4]  <= o_preset_index;
          o_rdata[srs_pkg::ST_SEL_LSB +: 3]     <= o_ref_selector;
          o_rdata[srs_pkg::ST_APPLIED_LSB +: 3] <= applied_mode_reg;
        end
        else
        begin
          for (int k = 0; k < srs_pkg::NUM_PRESETS; k++)
            if (i_addr == srs_pkg::ADDR_W'(srs_pkg::OFF_PRESET_BASE +
                                           k * srs_pkg::PRESET_STRIDE))
              o_rdata <= srs_pkg::DATA_W'(preset_reg[k]);
        end
      end
    end
  end

endmodule

// ==== test/srs_selector_checker.sv ====
// assertions on the ports of the speed reference source selector, bound to it
// assumes one clock domain; i_ce is driven by the bench and may drop for a while
`timescale 1ns/1ps
module srs_selector_checker #(
  parameter int REF_W  = 16,
  parameter int FINE_W = 8
) (
  // clock and reset
  input logic                       i_core_clk,
  input logic                       i_reset_n,
  // register port and sequencing inputs
  input logic                       i_ce,
  input logic                       i_wr,
  input logic                       i_rd,
  input logic [srs_pkg::DATA_W-1:0] o_rdata,
  input logic                       i_selector_input_hi,
  input logic                       i_panel_run_key,
  input logic                       i_panel_stop_key,
  input logic                       i_ext_run,
  input logic [1:0]                 i_drive_state,
  input logic                       i_drive_reset,
  // selector outputs
  input logic [REF_W+FINE_W-1:0]    o_reference,
  input logic [2:0]                 o_ref_selector,
  input logic [3:0]                 o_preset_index,
  input logic                       o_run_cmd,
  input logic                       o_jog_fwd,
  input logic [2:0]                 o_lo_dest,
  input logic [2:0]                 o_hi_dest
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  property p_rdata_idle;
    i_ce && !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");
  property p_panel_nojog;
    o_ref_selector == srs_pkg::SEL_PANEL |-> !o_jog_fwd && o_preset_index == 4'h0;
  endproperty
  a_panel_nojog: assert property (p_panel_nojog) else $error("jog active in panel mode");
  // a mode write one cycle back makes the reported source stale, so skip those cycles
  property p_panel_run;
    o_ref_selector == srs_pkg::SEL_PANEL && !$past(i_wr) && i_panel_run_key && !i_panel_stop_key
      |-> ##[1:2] o_run_cmd;
  endproperty
  a_panel_run: assert property (p_panel_run) else $error("panel run key ignored");
  property p_ext_run;
    i_ce && o_ref_selector != srs_pkg::SEL_PANEL && !$past(i_wr) |=> o_run_cmd == $past(i_ext_run);
  endproperty
  a_ext_run: assert property (p_ext_run) else $error("run command not following input");
  property p_jog_run;
    i_ce && i_drive_state == srs_pkg::DRV_RUN |=> !o_jog_fwd;
  endproperty
  a_jog_run: assert property (p_jog_run) else $error("jog accepted while running");
  property p_fine_hold;
    o_ref_selector == srs_pkg::SEL_FINE && !$past(i_wr) |=> $stable(o_reference);
  endproperty
  a_fine_hold: assert property (p_fine_hold) else $error("fine reference moved");
  property p_dest_hold;
    $changed(o_lo_dest) || $changed(o_hi_dest) |-> $past(i_wr) || $past(i_wr, 2)
      || $past(i_drive_reset) || $past(i_drive_reset, 2);
  endproperty
  a_dest_hold: assert property (p_dest_hold) else $error("routing changed without cause");
  property p_hi_jog;
    i_ce && o_hi_dest == srs_pkg::DEST_JOG_FWD && i_selector_input_hi && !$past(i_wr)
      && i_drive_state != srs_pkg::DRV_RUN && o_ref_selector != srs_pkg::SEL_PANEL |=> o_jog_fwd;
  endproperty
  a_hi_jog: assert property (p_hi_jog) else $error("jog terminal ignored");
endmodule

bind srs_selector srs_selector_checker #(.REF_W(REF_W), .FINE_W(FINE_W)) u_srs_chk (
  .i_core_clk, .i_reset_n, .i_ce, .i_wr, .i_rd, .o_rdata, .i_selector_input_hi,
  .i_panel_run_key, .i_panel_stop_key, .i_ext_run, .i_drive_state, .i_drive_reset,
  .o_reference, .o_ref_selector, .o_preset_index, .o_run_cmd, .o_jog_fwd, .o_lo_dest,
  .o_hi_dest);

// ==== test/srs_term_panel.sv ====
// far-side model: the two selector terminals and the panel keys
// assumes the bench commands levels at a clock edge; contacts follow one cycle later
`timescale 1ns/1ps
module srs_term_panel (
  // clock
  input  wire logic       i_core_clk,
  // commands from the bench
  input  wire logic [1:0] i_code,
  input  wire logic       i_run_press,
  input  wire logic       i_stop_press,
  // contacts into the selector
  output logic            o_lo,
  output logic            o_hi,
  output logic            o_run_key,
  output logic            o_stop_key
);
  // contacts never move in the same edge as the command, like real wiring delay
  always_ff @(posedge i_core_clk)
  begin
    {o_hi, o_lo} <= i_code;
    o_run_key    <= i_run_press;
    o_stop_key   <= i_stop_press;
  end
endmodule

// ==== test/tb.sv ====
// self-checking bench for the speed reference source selector
// assumes the checker is bound and the terminal/panel model drives the contacts
`timescale 1ns/1ps
module tb;
  localparam int SCANP = 5;
  logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, drst = 1'b0;
  logic        xrun = 1'b0, xjog = 1'b0, prun = 1'b0, pstop = 1'b0, ce = 1'b1;
  logic [1:0]  code = 2'h0, dstate = 2'h1;
  logic [7:0]  addr = 8'h00, fn;
  logic [31:0] wdata = 32'h0000_0000;
  logic [15:0] a1 = 16'h0000, a2 = 16'h0000, pnl, crs;
  logic [15:0] pre [8];
  wire  [31:0] rdata;
  wire  [23:0] ref_o;
  wire  [3:0]  idx;
  wire  [2:0]  sel, ldst, hdst;
  wire         run, jog, t_lo, t_hi, k_run, k_stop;
  int          md = 0, ch = 0, err_total = 0, samples_checked = 0;

  srs_selector #(.SCAN_RESET(8)) DUT (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_selector_input_lo(t_lo),
    .i_selector_input_hi(t_hi), .i_analog1(a1), .i_analog2(a2), .i_panel_run_key(k_run),
    .i_panel_stop_key(k_stop), .i_ext_run(xrun), .i_ext_jog(xjog), .i_drive_state(dstate),
    .i_drive_reset(drst), .o_reference(ref_o), .o_ref_selector(sel), .o_preset_index(idx),
    .o_run_cmd(run), .o_jog_fwd(jog), .o_lo_dest(ldst), .o_hi_dest(hdst));
  srs_term_panel u_far (.i_core_clk(clk), .i_code(code), .i_run_press(prun),
    .i_stop_press(pstop), .o_lo(t_lo), .o_hi(t_hi), .o_run_key(k_run), .o_stop_key(k_stop));

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  task complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // two pipeline stages (far-side contact, then selector) need three edges
  task settle;
    repeat (3) @(negedge clk);
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata);
  endtask

  task setmode(input int m);
    wreg(srs_pkg::OFF_MODE, m);
    md = m;
    @(posedge clk);
    drst <= 1'b1;
    @(posedge clk);
    drst <= 1'b0;
    settle();
  endtask

  task term(input logic [1:0] c);
    @(posedge clk);
    code <= c;
    settle();
  endtask

  task key(input logic r, input logic s);
    @(posedge clk);
    prun <= r;
    pstop <= s;
    @(posedge clk);
    prun <= 1'b0;
    pstop <= 1'b0;
    settle();
  endtask

  task chk_out;
    int          ix;
    logic [23:0] r;
    ix = (ch >= 2 && ch <= 8) ? ch : (ch == 0 && md >= 1 && md <= 3) ? 1 + code : 1;
    r = ix > 1 ? {pre[ix-1], 8'h00} : md == 3 ? {pre[0], 8'h00} :
        (md == 2 || (md == 0 && code[0])) ? {a2, 8'h00} : {a1, 8'h00};
    if (md == 4) r = {pnl, 8'h00};
    if (md == 5) r = {crs, fn};
    if (md >= 4) ix = 0;
    chk("preset_index", ix, idx);
    chk("ref_selector", (md == 0) ? 1 + code[0] : md, sel);
    chk("reference", r, ref_o);
  endtask

  initial
  begin
    int i, j, c, n;
    i = $urandom(32'h0000_633f);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    a1 <= 16'($urandom);
    a2 <= 16'($urandom);
    rchk(srs_pkg::OFF_MODE, 0, "mode_reset");
    rchk(srs_pkg::OFF_CHOICE, 0, "choice_reset");
    rchk(srs_pkg::OFF_AUTOCFG_DIS, 0, "autocfg_reset");
    rchk(8'hFC, 0, "unmapped_read");
    for (i = 0; i < 8; i++)
    begin
      pre[i] = 16'($urandom);
      wreg(srs_pkg::OFF_PRESET_BASE + 8'(4 * i), {16'h0000, pre[i]});
    end
    for (i = 0; i < 8; i++)
      rchk(srs_pkg::OFF_PRESET_BASE + 8'(4 * i), {16'h0000, pre[i]}, "preset");
    wreg(srs_pkg::OFF_MODE, 6);
    rchk(srs_pkg::OFF_MODE, 0, "mode_refused");
    wreg(srs_pkg::OFF_CHOICE, 10);
    rchk(srs_pkg::OFF_CHOICE, 0, "choice_refused");
    wreg(srs_pkg::OFF_MODE, 1);
    settle();
    chk("lo_dest_held", 1, ldst);
    setmode(1);
    chk("lo_dest_auto", 2, ldst);
    chk("hi_dest_auto", 3, hdst);
    wreg(srs_pkg::OFF_LO_DEST, 0);
    settle();
    chk("lo_dest_locked", 2, ldst);
    for (i = 1; i <= 3; i++)
    begin
      setmode(i);
      for (j = 0; j < 4; j++)
      begin
        term(2'(j));
        chk_out();
      end
    end
    for (i = 1; i <= 8; i++)
    begin
      ch = i;
      wreg(srs_pkg::OFF_CHOICE, i);
      term(2'($urandom));
      chk_out();
    end
    ch = 0;
    wreg(srs_pkg::OFF_CHOICE, 0);
    setmode(0);
    for (j = 0; j < 4; j++)
    begin
      term(2'(j));
      chk_out();
    end
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      dstate <= 2'(i);
      settle();
      chk("jog_terminal", i != 0, jog);
    end
    pnl = 16'($urandom);
    wreg(srs_pkg::OFF_PANEL_REF, pnl);
    xrun <= 1'b1;
    xjog <= 1'b1;
    setmode(4);
    chk_out();
    chk("panel_jog", 0, jog);
    chk("panel_ext_run", 0, run);
    key(1'b1, 1'b0);
    chk("panel_run", 1, run);
    key(1'b1, 1'b1);
    chk("panel_stop", 0, run);
    crs = 16'($urandom);
    fn = 8'($urandom);
    wreg(srs_pkg::OFF_COARSE_REF, crs);
    wreg(srs_pkg::OFF_FINE_REF, fn);
    setmode(5);
    term(2'h3);
    chk_out();
    setmode(1);
    wreg(srs_pkg::OFF_SCAN_PERIOD, SCANP);
    rchk(srs_pkg::OFF_SCAN_PERIOD, SCANP, "scan_period");
    wreg(srs_pkg::OFF_CHOICE, 9);
    for (i = 0; i < 40 && idx !== 4'h2; i++)
      @(negedge clk);
    chk("scan_start", 2, idx);
    for (j = 0; j < 10; j++)
    begin
      c = idx;
      n = 0;
      while (idx === 4'(c) && n < 40)
      begin
        @(negedge clk);
        n++;
        if (n == 2) chk("scan_ref", c == 1 ? {a1, 8'h00} : {pre[c-1], 8'h00}, ref_o);
      end
      chk("scan_dwell", SCANP, n);
      chk("scan_step", c % 8 + 1, idx);
    end
    wreg(srs_pkg::OFF_CHOICE, 0);
    term(2'h0);
    chk_out();
    // enable low: a terminal change must not reach the outputs until it rises again
    @(posedge clk);
    ce <= 1'b0;
    term(2'h3);
    chk("ce_freeze", 1, idx);
    @(posedge clk);
    ce <= 1'b1;
    settle();
    chk_out();
    rchk(srs_pkg::OFF_STATUS, 32'h0000_0114, "status");
    wreg(srs_pkg::OFF_AUTOCFG_DIS, 1);
    wreg(srs_pkg::OFF_LO_DEST, 4);
    setmode(3);
    chk("lo_dest_manual", 4, ldst);
    chk("hi_dest_manual", 3, hdst);
    complete_run();
  end
endmodule
